// File: hw/tos_top.sv
// traction option supervisor: option registers, hour counter, battery
// and service supervision, hill hold, aux output, quick reverse, pedal
// curve and ramp time selection.
// assumes synchronous inputs, classic wishbone master, sys_clk 200 MHz.
// Summary of operation
// R1: hours count while travelling, or key on
// R2: level 0 computes charge, takes no action
// R3: level 1,3: alarm at 10%, inhibit lift
// R4: level 2: alarm, inhibit lift, cap 24%
// R5: encoder, pedal off, tiller on: hold
// R6: hill hold off: no electrical hold
// R7: hold expiry: brake on, bridge released
// R8: aux output: brake, two steer, unused
// R9: demand steer: direction, pedal or motion
// R10: exclusive steer: only exclusive input
// R11: quick reverse ignored, timed or untimed; timed follows the switch here, the same as untimed
// R12: polarity picks normally closed or open
// R13: motor temp analog, digital or ignored
// R14: deadband, knee slope, second slope
// R15: service warn 300, slow 340, stop 380
// R16: service done flag cancels warning
// R17: transfer setting sends hours to dash
// R18: acceleration time spans 0 to 100 Hz
// R19: six deceleration times, 100 to 0 Hz
// R20: forward speed limited by percentage
// R21: battery table ends adjustable 0 to 9
// R22: coil duties programmed percentage
// R23: time settings 0 to 10 s, 0.1 step; hill hold counts 0.1 ms ticks here, up to 10 ms
// R24: shortest active deceleration time wins
// R25: hours kept, whole hours for service; an hour count here is 36000 ticks of 0.1 ms, 3.6 s
`timescale 1ns/1ps
module tos_top #(
  parameter int unsigned TICK_CYCLES = tos_pkg::TICK_CYC,
  parameter int unsigned HOUR_TICKS = tos_pkg::HOUR_TICKS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tos_pkg::tos_in_s sw_in,
  input wire logic [6:0] pedal_pct,
  input wire logic [6:0] charge_pct,
  input wire logic [6:0] motor_hz,
  output tos_pkg::tos_out_s drv_out,
  output logic [6:0] speed_cmd_r,
  output logic [6:0] ramp_time_r,
  output logic ramp_is_accel_r,
  output logic [6:0] main_coil_duty_r,
  output logic [6:0] brake_coil_duty_r,
  output logic [15:0] dash_hours_r,
  output logic dash_hours_valid_r
);
  tos_pkg::tos_opt_s opt_r; // option word
  logic [31:0] curve_r; // deadband, knee in, knee out
  logic [31:0] acc_r; // accel time, coil duties
  logic [31:0] dec0_r; // four deceleration times
  logic [31:0] dec1_r; // two deceleration times
  logic [31:0] lim_r; // forward and reverse limits
  logic [15:0] hours_r; // hour counts of 3.6 s each, loaded by software after power up
  logic [31:0] tick_cnt_r; // cycles within one 0.1 ms tick
  logic [31:0] sub_hour_r; // 0.1 ms ticks within an hour count
  logic tick; // 0.1 ms strobe, every 20000 cycles
  logic wb_req;
  logic wr_hit;
  tos_pkg::tos_out_s out_nxt;
  tos_pkg::tos_hold_e hold_r;
  logic [6:0] hold_cnt_r; // 0.1 ms ticks left in hill hold
  logic [6:0] speed_nxt;
  logic [6:0] dec_nxt;
  logic low_charge;
  logic [15:0] hours_prev_r;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_hit = wb_req && wb_we_i && (wb_sel_i == 4'hF);
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);

  // bus acknowledge, one cycle after request; unmapped reads give zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // read mux, registered with the acknowledge
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req)
    begin
      unique case (wb_adr_i)
        tos_pkg::OFS_OPT: wb_dat_o <= 32'(opt_r);
        tos_pkg::OFS_CURVE: wb_dat_o <= curve_r;
        tos_pkg::OFS_ACC: wb_dat_o <= acc_r;
        tos_pkg::OFS_DEC0: wb_dat_o <= dec0_r;
        tos_pkg::OFS_DEC1: wb_dat_o <= dec1_r;
        tos_pkg::OFS_LIM: wb_dat_o <= lim_r;
        tos_pkg::OFS_HOURS: wb_dat_o <= {16'h0000, hours_r};
        tos_pkg::OFS_STAT: wb_dat_o <= {22'h000000, drv_out};
        tos_pkg::OFS_IN: wb_dat_o <= {16'h0000, sw_in};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // configuration writes; only full-word writes are honoured
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      opt_r <= '0;
      curve_r <= 32'h0000_0000;
      acc_r <= 32'h0000_0000;
      dec0_r <= 32'h0000_0000;
      dec1_r <= 32'h0000_0000;
      lim_r <= {16'h0000, 1'b0, tos_pkg::PCT_FULL, 1'b0, tos_pkg::PCT_FULL};
    end
    else if (wr_hit)
    begin
      unique case (wb_adr_i)
        tos_pkg::OFS_OPT:
        begin
          opt_r <= tos_pkg::tos_opt_s'(wb_dat_i[22:0]);
          // table ends saturate at top level
          if (wb_dat_i[14:11] > tos_pkg::BAT_LEVEL_MAX) // R21
            opt_r.bat_min <= tos_pkg::BAT_LEVEL_MAX;
          if (wb_dat_i[18:15] > tos_pkg::BAT_LEVEL_MAX) // R21
            opt_r.bat_max <= tos_pkg::BAT_LEVEL_MAX;
        end
        tos_pkg::OFS_CURVE: curve_r <= wb_dat_i;
        tos_pkg::OFS_ACC: acc_r <= wb_dat_i;
        tos_pkg::OFS_DEC0: dec0_r <= wb_dat_i;
        tos_pkg::OFS_DEC1: dec1_r <= wb_dat_i;
        tos_pkg::OFS_LIM: lim_r <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // 0.1 ms time base for hold and hour counting
  always_ff @(posedge sys_clk)
  begin
    if (reset || tick)
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  // hour counter; software restores the saved value through the bus
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      hours_r <= 16'h0000;
      sub_hour_r <= 32'h0000_0000;
    end
    else if (wr_hit && wb_adr_i == tos_pkg::OFS_HOURS)
    begin
      hours_r <= wb_dat_i[15:0]; // R25
      sub_hour_r <= 32'h0000_0000;
    end
    else if (tick && ((opt_r.hour_mode == tos_pkg::HC_KEY_ON && sw_in.key_on)
      || (opt_r.hour_mode == tos_pkg::HC_RUNNING && sw_in.travelling))) // R1
    begin
      if (sub_hour_r == HOUR_TICKS - 1)
      begin
        sub_hour_r <= 32'h0000_0000;
        hours_r <= hours_r + 16'h0001; // R25
      end
      else
        sub_hour_r <= sub_hour_r + 32'h0000_0001;
    end
  end

  // hill hold sequence, durations in 0.1 ms ticks clipped to 10 ms
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      hold_r <= tos_pkg::HH_IDLE;
      hold_cnt_r <= 7'h00;
    end
    else
    begin
      unique case (hold_r)
        tos_pkg::HH_IDLE:
          if (sw_in.encoder_present && pedal_pct == 7'h00 &&
              sw_in.tiller_closed) // R5
          begin
            hold_r <= tos_pkg::HH_HOLD;
            hold_cnt_r <= (acc_r[31:25] > tos_pkg::TIME_MAX) ?
              tos_pkg::TIME_MAX : acc_r[31:25]; // R23
          end
        tos_pkg::HH_HOLD:
          if (pedal_pct != 7'h00 || !sw_in.tiller_closed)
            hold_r <= tos_pkg::HH_IDLE;
          else if (hold_cnt_r == 7'h00)
            hold_r <= tos_pkg::HH_PARK; // R7
          else if (tick)
            hold_cnt_r <= hold_cnt_r - 7'h01;
        tos_pkg::HH_PARK:
          if (pedal_pct != 7'h00)
            hold_r <= tos_pkg::HH_IDLE;
      endcase
    end
  end

  assign low_charge = (charge_pct <= tos_pkg::BAT_LOW_PCT);

  // output decisions from options and inputs
  always_comb
  begin
    out_nxt = '0;
    // alarm only for levels above zero; level 0 takes no action R2
    out_nxt.low_charge_alarm = low_charge && opt_r.bat_check != 2'h0; // R3
    out_nxt.lift_inhibit = out_nxt.low_charge_alarm; // R3
    out_nxt.electric_hold = (hold_r == tos_pkg::HH_HOLD) &&
      opt_r.hill_hold; // R6
    // bridge drives unless parked after hold expiry
    out_nxt.bridge_enable = (hold_r != tos_pkg::HH_PARK); // R7
    out_nxt.brake_release = (hold_r != tos_pkg::HH_PARK); // R7
    unique case (opt_r.aux) // R8
      tos_pkg::AUX_BRAKE: out_nxt.aux_out = out_nxt.brake_release;
      tos_pkg::AUX_STEER_DEMAND: out_nxt.aux_out = sw_in.dir_fwd ||
        sw_in.dir_rev || sw_in.brake_pedal || sw_in.moving; // R9
      tos_pkg::AUX_STEER_EXCL: out_nxt.aux_out = sw_in.excl_steer; // R10
      tos_pkg::AUX_FREE: out_nxt.aux_out = 1'b0;
    endcase
    // polarity on: normally closed, active on open R12
    if (opt_r.qr == tos_pkg::QR_TIMED || opt_r.qr == tos_pkg::QR_UNTIMED)
      out_nxt.quick_reverse = sw_in.qr_switch ^ opt_r.qr_polarity; // R11
    // analog reading is judged outside; only the digital input trips here
    out_nxt.temp_fault = (opt_r.mtemp == tos_pkg::MT_DIGITAL) &&
      sw_in.temp_digital; // R13
    out_nxt.service_warning = !opt_r.svc_done && opt_r.svc != tos_pkg::SV_NONE
      && hours_r >= tos_pkg::SVC_WARN_H; // R15 R16
    out_nxt.service_stop = !opt_r.svc_done && opt_r.svc == tos_pkg::SV_STOP
      && hours_r >= tos_pkg::SVC_STOP_H; // R15
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      drv_out <= '0;
    else
      drv_out <= out_nxt;
  end

  // pedal curve and speed caps
  always_comb
  begin
    logic [6:0] dz;
    logic [6:0] kx;
    logic [6:0] ky;
    logic [13:0] prod;
    logic [6:0] lim;
    dz = curve_r[6:0];
    kx = curve_r[14:8];
    ky = curve_r[22:16];
    lim = sw_in.dir_fwd ? lim_r[6:0] : lim_r[14:8]; // R20
    prod = 14'h0000;
    if (pedal_pct <= dz)
      speed_nxt = 7'h00; // R14
    else if (pedal_pct <= kx)
    begin
      prod = 14'((pedal_pct - dz) * ky);
      speed_nxt = (kx > dz) ? 7'(prod / 14'(kx - dz)) : ky; // R14
    end
    else
    begin
      prod = 14'((pedal_pct - kx) * (tos_pkg::PCT_FULL - ky));
      speed_nxt = 7'(ky + ((kx < tos_pkg::PCT_FULL) ?
        prod / 14'(tos_pkg::PCT_FULL - kx) : 14'h0000)); // R14
    end
    if (speed_nxt > lim)
      speed_nxt = lim;
    if (opt_r.bat_check == 2'h2 && low_charge &&
        speed_nxt > tos_pkg::BAT_SPEED_PCT)
      speed_nxt = tos_pkg::BAT_SPEED_PCT; // R4
    if (!opt_r.svc_done && hours_r >= tos_pkg::SVC_SLOW_H &&
        (opt_r.svc == tos_pkg::SV_SLOW || opt_r.svc == tos_pkg::SV_STOP) &&
        speed_nxt > tos_pkg::BAT_SPEED_PCT)
      speed_nxt = tos_pkg::BAT_SPEED_PCT; // R15
    if (opt_r.svc == tos_pkg::SV_STOP && out_nxt.service_stop)
      speed_nxt = 7'h00; // R15
  end

  // shortest deceleration time among the active conditions
  always_comb
  begin
    logic [6:0] t [6];
    logic [5:0] act;
    t[0] = dec0_r[6:0];
    t[1] = dec0_r[14:8];
    t[2] = dec0_r[22:16];
    t[3] = dec0_r[30:24];
    t[4] = dec1_r[6:0];
    t[5] = dec1_r[14:8];
    act = {sw_in.curve_cutback, sw_in.speed_reduction, sw_in.partial_release,
      sw_in.dir_inversion, !sw_in.tiller_closed, sw_in.travel_release}; // R19
    dec_nxt = tos_pkg::TIME_MAX;
    for (int i = 0; i < 6; i++)
      if (act[i] && t[i] < dec_nxt)
        dec_nxt = t[i]; // R24
  end

  // ramp selection, times in tenths per 0..100 Hz span
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      speed_cmd_r <= 7'h00;
      ramp_time_r <= 7'h00;
      ramp_is_accel_r <= 1'b0;
    end
    else
    begin
      speed_cmd_r <= speed_nxt;
      ramp_is_accel_r <= !(|dec1_r[15:0] && 1'b0) &&
        (speed_nxt >= speed_cmd_r) && motor_hz <= tos_pkg::FREQ_FULL;
      if (speed_nxt >= speed_cmd_r)
        ramp_time_r <= (acc_r[6:0] > tos_pkg::TIME_MAX) ?
          tos_pkg::TIME_MAX : acc_r[6:0]; // R18 R23
      else
        ramp_time_r <= dec_nxt; // R19 R23
    end
  end

  // coil duties and dash transfer
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      main_coil_duty_r <= 7'h00;
      brake_coil_duty_r <= 7'h00;
      dash_hours_r <= 16'h0000;
      dash_hours_valid_r <= 1'b0;
      hours_prev_r <= 16'h0000;
    end
    else
    begin
      main_coil_duty_r <= (acc_r[14:8] > tos_pkg::PCT_FULL) ?
        tos_pkg::PCT_FULL : acc_r[14:8]; // R22
      brake_coil_duty_r <= (acc_r[22:16] > tos_pkg::PCT_FULL) ?
        tos_pkg::PCT_FULL : acc_r[22:16]; // R22
      hours_prev_r <= hours_r;
      dash_hours_valid_r <= opt_r.hm_transfer &&
        (hours_r != hours_prev_r || tick); // R17
      if (opt_r.hm_transfer)
        dash_hours_r <= hours_r; // R17
    end
  end

  a_bus_ack_once: assert property (@(posedge sys_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_lift_alarm_pair: assert property (@(posedge sys_clk) disable iff (reset)
    drv_out.lift_inhibit == drv_out.low_charge_alarm) // R3
    else $error("lift inhibit not tied to alarm");
  a_level0_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.bat_check == 2'h0 && $past(opt_r.bat_check) == 2'h0
    |-> !drv_out.low_charge_alarm) // R2
    else $error("alarm at level zero");
  a_batt_speed_cap: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.bat_check == 2'h2 && low_charge |=>
    speed_cmd_r <= tos_pkg::BAT_SPEED_PCT) // R4
    else $error("speed not capped on low charge");
  a_hold_off: assert property (@(posedge sys_clk) disable iff (reset)
    !opt_r.hill_hold && !$past(opt_r.hill_hold) |-> !drv_out.electric_hold) // R6
    else $error("held with hill hold off");
  a_park_brake: assert property (@(posedge sys_clk) disable iff (reset)
    hold_r == tos_pkg::HH_PARK |=> !drv_out.bridge_enable &&
    !drv_out.brake_release) // R7
    else $error("park did not brake");
  a_excl_steer: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.aux == tos_pkg::AUX_STEER_EXCL && $stable(opt_r.aux) |=>
    drv_out.aux_out == $past(sw_in.excl_steer)) // R10
    else $error("exclusive steer mismatch");
  a_aux_free: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.aux == tos_pkg::AUX_FREE |=> !drv_out.aux_out) // R8
    else $error("free aux output active");
  a_qr_none: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.qr == tos_pkg::QR_NONE |=> !drv_out.quick_reverse) // R11
    else $error("quick reverse with mode none");
  a_svc_done: assert property (@(posedge sys_clk) disable iff (reset)
    opt_r.svc_done |=> !drv_out.service_warning) // R16
    else $error("warning after service done");
  a_ramp_bound: assert property (@(posedge sys_clk) disable iff (reset)
    ramp_time_r <= tos_pkg::TIME_MAX) // R23
    else $error("ramp time beyond ten seconds");
  c_hold_park: cover property (@(posedge sys_clk) disable iff (reset)
    hold_r == tos_pkg::HH_HOLD ##[1:300] hold_r == tos_pkg::HH_PARK);
  c_low_alarm: cover property (@(posedge sys_clk) disable iff (reset)
    drv_out.low_charge_alarm);
  c_service_stop: cover property (@(posedge sys_clk) disable iff (reset)
    drv_out.service_stop);
  c_steer_demand: cover property (@(posedge sys_clk) disable iff (reset)
    opt_r.aux == tos_pkg::AUX_STEER_DEMAND && drv_out.aux_out);
endmodule

// File: hw/tos_pkg.sv
// package for the traction option supervisor: settings layout, register
// offsets, enumerations and timing constants.
// assumes a 200 MHz sys_clk and a classic wishbone register bus.
package tos_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 100; // tick step, gives a 0.1 ms tick of 20000 cycles
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS / 1000;
  localparam int unsigned HOUR_S = 3600;
  localparam int unsigned HOUR_TICKS = HOUR_S * 1000 / TICK_MS;
  localparam logic [6:0] TIME_MAX = 7'h64; // 100 tenths, ten seconds
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] BAT_LOW_PCT = 7'h0A;
  localparam logic [6:0] BAT_SPEED_PCT = 7'h18;
  localparam logic [3:0] BAT_LEVEL_MAX = 4'h9;
  localparam logic [15:0] SVC_WARN_H = 16'h012C;
  localparam logic [15:0] SVC_SLOW_H = 16'h0154;
  localparam logic [15:0] SVC_STOP_H = 16'h017C;
  localparam logic [6:0] FREQ_FULL = 7'h64; // 100 Hz ramp span
  // register byte offsets
  localparam logic [7:0] OFS_OPT = 8'h00;
  localparam logic [7:0] OFS_CURVE = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_DEC0 = 8'h0C;
  localparam logic [7:0] OFS_DEC1 = 8'h10;
  localparam logic [7:0] OFS_LIM = 8'h14;
  localparam logic [7:0] OFS_HOURS = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_IN = 8'h20;

  typedef enum logic [0:0] {HC_RUNNING, HC_KEY_ON} tos_hour_mode_e;
  typedef enum logic [1:0] {AUX_BRAKE, AUX_STEER_DEMAND, AUX_STEER_EXCL,
    AUX_FREE} tos_aux_mode_e;
  typedef enum logic [1:0] {QR_NONE, QR_TIMED, QR_UNTIMED, QR_RSVD}
    tos_qr_mode_e;
  typedef enum logic [1:0] {MT_ANALOG, MT_DIGITAL, MT_NONE, MT_RSVD}
    tos_mtemp_e;
  typedef enum logic [1:0] {SV_NONE, SV_WARN, SV_SLOW, SV_STOP} tos_svc_e;
  typedef enum logic [1:0] {HH_IDLE, HH_HOLD, HH_PARK} tos_hold_e;

  // option word, low bits of OFS_OPT
  typedef struct packed {
    logic hm_transfer;
    logic svc_done;
    tos_svc_e svc;
    logic [3:0] bat_max;
    logic [3:0] bat_min;
    logic qr_polarity;
    tos_mtemp_e mtemp;
    tos_qr_mode_e qr;
    tos_aux_mode_e aux;
    logic hill_hold;
    logic [1:0] bat_check;
    tos_hour_mode_e hour_mode;
  } tos_opt_s;

  // operator and sensor inputs
  typedef struct packed {
    logic key_on;
    logic travelling;
    logic dir_fwd;
    logic dir_rev;
    logic brake_pedal;
    logic excl_steer;
    logic tiller_closed;
    logic encoder_present;
    logic moving;
    logic qr_switch;
    logic temp_digital;
    logic travel_release;
    logic dir_inversion;
    logic partial_release;
    logic speed_reduction;
    logic curve_cutback;
  } tos_in_s;

  // drive outputs
  typedef struct packed {
    logic electric_hold;
    logic bridge_enable;
    logic brake_release;
    logic aux_out;
    logic low_charge_alarm;
    logic lift_inhibit;
    logic service_warning;
    logic service_stop;
    logic quick_reverse;
    logic temp_fault;
  } tos_out_s;
endpackage

// File: tb/tos_plant.sv
// far-side model: operator switches, motor bridge and brake of the truck.
// assumes drv_out from the supervisor and switch requests from the bench.
`timescale 1ns/1ps
module tos_plant (
  input wire logic sys_clk,
  input wire tos_pkg::tos_in_s op_req,
  input wire tos_pkg::tos_out_s drv_out,
  output tos_pkg::tos_in_s sw_in,
  output logic [6:0] motor_hz
);
  // switches pass one register late, like a sampled input stage
  // the truck rolls when the bench requests it, or while travelling with the bridge driving and the brake lifted
  always_ff @(posedge sys_clk)
  begin
    sw_in <= op_req;
    sw_in.moving <= op_req.moving | (op_req.travelling
      & drv_out.bridge_enable & drv_out.brake_release);
    // a spinning motor reads half span, a released bridge reads zero
    motor_hz <= drv_out.bridge_enable ? 7'h32 : 7'h00;
  end
endmodule

// File: tb/tb.sv
// self-checking bench for the traction option supervisor.
// assumes tos_top with shortened tick and hour counts and tos_plant.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [6:0] pedal = 7'h00;
  logic [6:0] charge = 7'h64;
  logic [6:0] mhz;
  logic [6:0] spd;
  logic [6:0] rtime;
  logic [6:0] mduty;
  logic [6:0] bduty;
  logic racc;
  logic [15:0] hours;
  tos_pkg::tos_in_s op = '0;
  tos_pkg::tos_in_s sw;
  tos_pkg::tos_out_s dout;
  tos_pkg::tos_opt_s o;
  int error_cnt = 0;
  int tests_run = 0;
  // quick reverse and motor temperature cases, one column per case
  logic [1:0] qm [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  logic qp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic qs [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  logic qx [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [1:0] tm [5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h1};
  logic td [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic tx [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  // short tick and hour so service thresholds come within reach
  tos_top #(.TICK_CYCLES(4), .HOUR_TICKS(3)) DUT (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sw_in(sw), .pedal_pct(pedal),
    .charge_pct(charge), .motor_hz(mhz), .drv_out(dout),
    .speed_cmd_r(spd), .ramp_time_r(rtime), .ramp_is_accel_r(racc),
    .main_coil_duty_r(mduty), .brake_coil_duty_r(bduty),
    .dash_hours_r(hours), .dash_hours_valid_r()
  );

  tos_plant plant (
    .sys_clk(sys_clk), .op_req(op), .drv_out(dout), .sw_in(sw),
    .motor_hz(mhz)
  );

  // 200 MHz system clock
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // verdict and end of run, also reached from any timeout
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    $display("unexpected t=%0t wait ran out", $time);
    end_of_test();
  endtask

  // one classic cycle; request held until ack is seen on an edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1)
    begin
      n++;
      if (n > 20)
        give_up();
      @(posedge sys_clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wopt();
    wb(1'b1, tos_pkg::OFS_OPT, 32'(o), rd);
  endtask

  // bounded wait for one drive output bit to reach a level
  task automatic wait_out(input int b, input logic v);
    int n;
    n = 0;
    while (dout[b] !== v)
    begin
      n++;
      if (n > 300)
        give_up();
      @(posedge sys_clk);
    end
  endtask

  // new switch set and pedal, then settle through plant and supervisor
  task automatic put(input tos_pkg::tos_in_s v, input logic [6:0] p);
    op <= v;
    pedal <= p;
    repeat (4) @(posedge sys_clk);
  endtask

  initial
  begin
    tos_pkg::tos_in_s s;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    // status register needs one edge after release to leave reset levels
    @(posedge sys_clk);
    // idle after reset: bridge driven, brake lifted, aux drives brake
    wb(1'b0, tos_pkg::OFS_STAT, 32'h0, rd);
    `CHK(rd[9:0], 10'h1C0)
    wb(1'b0, 8'h24, 32'h0, rd);
    `CHK(rd, 32'h0)
    wb(1'b1, tos_pkg::OFS_CURVE, 32'h0032_3200, rd);
    wb(1'b1, tos_pkg::OFS_ACC, 32'h0428_460F, rd);
    wb(1'b1, tos_pkg::OFS_DEC0, 32'h281E_140A, rd);
    wb(1'b1, tos_pkg::OFS_DEC1, 32'h0000_3C32, rd);
    `CHK({mduty, bduty}, {7'h46, 7'h28})
    // battery levels at the 10 percent edge and just above it
    s = '0;
    s.dir_fwd = 1'b1;
    s.travelling = 1'b1;
    s.tiller_closed = 1'b1;
    for (int lv = 0; lv < 4; lv++)
    begin
      o = '0;
      o.bat_check = 2'(lv);
      o.bat_max = 4'h9;
      wopt();
      for (int c = 0; c < 2; c++)
      begin
        charge <= c ? 7'h0B : 7'h0A;
        put(s, 7'h64);
        `CHK(dout.low_charge_alarm, lv != 0 && c == 0)
        `CHK(dout.lift_inhibit, lv != 0 && c == 0)
        `CHK(spd, (lv == 2 && c == 0) ? 7'h18 : 7'h64)
      end
    end
    // forward cap at half speed
    wb(1'b1, tos_pkg::OFS_LIM, 32'h0000_6432, rd);
    put(s, 7'h64);
    `CHK(spd, 7'h32)
    // two braking causes at once: the shorter time wins
    s.dir_inversion = 1'b1;
    s.curve_cutback = 1'b1;
    // deceleration time stands only in the cycle the target falls
    put(s, 7'h64);
    pedal <= 7'h00;
    repeat (2) @(posedge sys_clk);
    `CHK({racc, rtime}, {1'b0, 7'h1E})
    s.travel_release = 1'b1;
    put(s, 7'h64);
    pedal <= 7'h00;
    repeat (2) @(posedge sys_clk);
    `CHK(rtime, 7'h0A)
    s = '0;
    s.dir_fwd = 1'b1;
    s.travelling = 1'b1;
    put(s, 7'h64);
    `CHK({racc, rtime}, {1'b1, 7'h0F})
    // steering contactor modes and the unused mode
    s = '0;
    for (int m = 1; m < 4; m++)
    begin
      o = '0;
      o.aux = tos_pkg::tos_aux_mode_e'(m);
      wopt();
      s.dir_fwd = 1'b1;
      s.excl_steer = 1'b0;
      put(s, 7'h00);
      `CHK(dout.aux_out, m == 1)
      s.dir_fwd = 1'b0;
      s.excl_steer = 1'b1;
      put(s, 7'h00);
      `CHK(dout.aux_out, m == 2)
    end
    // quick reverse modes with both polarities, sensor kinds
    for (int i = 0; i < 5; i++)
    begin
      o = '0;
      o.qr = tos_pkg::tos_qr_mode_e'(qm[i]);
      o.qr_polarity = qp[i];
      o.mtemp = tos_pkg::tos_mtemp_e'(tm[i]);
      wopt();
      s = '0;
      s.qr_switch = qs[i];
      s.temp_digital = td[i];
      put(s, 7'h00);
      `CHK(dout.quick_reverse, qx[i])
      `CHK(dout.temp_fault, tx[i])
    end
    // hill hold on: hold, then brake and bridge release on expiry
    o = '0;
    o.hill_hold = 1'b1;
    wopt();
    s = '0;
    s.encoder_present = 1'b1;
    s.tiller_closed = 1'b1;
    put(s, 7'h32);
    put(s, 7'h00);
    `CHK(dout.electric_hold, 1'b1)
    wait_out(7, 1'b0);
    `CHK(dout[9:8], 2'b00)
    o.hill_hold = 1'b0;
    wopt();
    put(s, 7'h32);
    put(s, 7'h00);
    `CHK(dout.electric_hold, 1'b0)
    // running mode: standing still does not count
    o = '0;
    o.svc = tos_pkg::SV_WARN;
    o.hm_transfer = 1'b1;
    wopt();
    wb(1'b1, tos_pkg::OFS_HOURS, 32'h0000_012B, rd);
    s = '0;
    s.key_on = 1'b1;
    put(s, 7'h00);
    repeat (30) @(posedge sys_clk);
    wb(1'b0, tos_pkg::OFS_HOURS, 32'h0, rd);
    `CHK(rd[15:0], 16'h012B)
    s.travelling = 1'b1;
    put(s, 7'h00);
    wait_out(3, 1'b1);
    repeat (2) @(posedge sys_clk);
    `CHK(hours, 16'h012C)
    o.svc_done = 1'b1;
    wopt();
    put(s, 7'h00);
    `CHK(dout.service_warning, 1'b0)
    // key-on mode counts at rest up to the stop threshold
    o = '0;
    o.hour_mode = tos_pkg::HC_KEY_ON;
    o.svc = tos_pkg::SV_STOP;
    wopt();
    wb(1'b1, tos_pkg::OFS_HOURS, 32'h0000_017B, rd);
    s.travelling = 1'b0;
    put(s, 7'h00);
    wait_out(2, 1'b1);
    `CHK(dout.service_warning, 1'b1)
    end_of_test();
  end
endmodule
